// file: bench/cfb_mem_model.sv
`timescale 1ns/1ps
// file array behind the block; answers from the held address
module cfb_mem_model (
	input wire logic ref_clk_in,
	input cfb_pkg::cfb_mem_t mem_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [4096];
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;
	// read bus not driven: show the inverse
	assign rdata_out = mem_in.rd ? mem[mem_in.addr] : ~mem[mem_in.addr];
	always @(posedge ref_clk_in) if (mem_in.wr) mem[mem_in.addr] <= mem_in.wdata;
endmodule // cfb_mem_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, valid = 0, ext = 0, neg = 0, skip = 0;
	logic [15:0] instr = 16'h0000, w;
	logic [3:0] bank_pointer_reg = 4'h0;
	logic [7:0] rdata;
	logic [7:0] sh [4096];
	cfb_pkg::cfb_q_t q;
	cfb_pkg::cfb_mem_t mem;
	logic [20:0] pc, pcm = 21'h0;
	logic pc_wr, flush, busy;
	logic [22:0] exp_q [$];
	logic [22:0] e, got;
	logic [21:0] tv [8] = '{{16'h9e5f, 6'h23}, {16'h9e60, 6'h23}, {16'h9280, 6'h05},
		{16'h937f, 6'h05}, {16'he67f, 6'h10}, {16'h9001, 6'h00}, {16'he680, 6'h10}, {16'he605, 6'h00}};
	int failures = 0, samples_checked = 0, cyc = 0;
	cfb_exec u_dut (.ref_clk_in(clk), .rst_in(rst), .instr_in(instr), .instr_valid_in(valid),
		.ext_set_in(ext), .neg_flag_in(neg), .bank_pointer_reg_in(bank_pointer_reg), .mem_rdata_in(rdata),
		.q_out(q), .mem_out(mem), .pc_out(pc), .pc_wr_out(pc_wr), .flush_out(flush),
		.busy_out(busy));
	cfb_mem_model u_mem (.ref_clk_in(clk), .mem_in(mem), .rdata_out(rdata));
	initial forever #50 clk = ~clk;
	task automatic end_sim();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// drive one word per instruction cycle and note what it must cause
	task automatic step(input logic [15:0] wd, input logic ex, n, input logic [3:0] bk);
		logic [11:0] a;
		logic x;
		do begin
			@(posedge clk);
			#1;
		end while (q !== cfb_pkg::CFB_Q1);
		instr = wd;
		valid = 1;
		ext = ex;
		neg = n;
		bank_pointer_reg = bk;
		x = !wd[8] && ex && wd[7:0] <= cfb_pkg::IDX_MAX;
		a = x ? {4'h0, wd[7:0]} : wd[8] ? {bk, wd[7:0]} : {wd[7:0] < cfb_pkg::QUICK_SPLIT ?
			cfb_pkg::QUICK_BANK : cfb_pkg::QUICK_HI_BANK, wd[7:0]};
		if (skip) skip = 0;
		else begin
			if (wd[15:12] == cfb_pkg::CLR_OPC) begin
				sh[a] = sh[a] & ~(8'h01 << wd[11:9]);
				exp_q.push_back({2'b00, x, a, sh[a]});
			end
			if (wd[15:8] == cfb_pkg::BRN_OPC && n) begin
				pcm = pcm + 21'h2 + {{12{wd[7]}}, wd[7:0], 1'b0};
				exp_q.push_back({2'b11, pcm});
				skip = 1;
			end else pcm = pcm + 21'h2;
		end
	endtask
	always @(negedge clk) begin
		cyc = cyc + 1;
		if (!rst) begin
			samples_checked = samples_checked + 1;
			if (busy !== (q !== cfb_pkg::CFB_Q1)) begin
				failures = failures + 1;
				$display("[FAIL] busy exp %b got %b", q !== cfb_pkg::CFB_Q1, busy);
			end
		end
		if (mem.wr === 1'b1 || pc_wr === 1'b1) begin
			samples_checked = samples_checked + 1;
			got = mem.wr ? {2'b00, mem.idx, mem.addr, mem.wdata} : {1'b1, flush, pc};
			e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
			if (got !== e) begin
				failures = failures + 1;
				$display("[FAIL] %s exp %h got %h", mem.wr ? "write" : "branch", e, got);
			end
		end
		if (cyc > 2000) begin
			failures = failures + 1;
			end_sim();
		end
	end
	initial begin
		void'($urandom(9203));
		for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ 8'h5a;
		repeat (10) @(posedge clk);
		#1 rst = 0;
		pcm = cfb_pkg::PC_STEP; // one empty slot is decoded before the first word
		// boundaries, sign extremes, word refused in the dead cycle
		foreach (tv[i]) step(tv[i][21:6], tv[i][5], tv[i][4], tv[i][3:0]);
		repeat (60) begin
			w = 16'($urandom);
			case (w[1:0])
				2'h0: w[15:12] = cfb_pkg::CLR_OPC;
				2'h1: w[15:8] = cfb_pkg::BRN_OPC;
				default: ;
			endcase
			step(w, 1'($urandom), 1'($urandom), 4'($urandom));
		end
		// take the last word away so it is not decoded again
		do begin
			@(posedge clk);
			#1;
		end while (q !== cfb_pkg::CFB_Q1);
		valid = 0;
		repeat (12) @(posedge clk);
		samples_checked = samples_checked + 1;
		if (exp_q.size() != 0) begin
			failures = failures + 1;
			$display("[FAIL] pending exp 0 got %0d", exp_q.size());
		end
		end_sim();
	end
endmodule // testbench

// file: design/cfb_exec.sv
`timescale 1ns/1ps
module cfb_exec (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [15:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic ext_set_in,
	input wire logic neg_flag_in,
	input wire logic [3:0] bank_pointer_reg_in,
	input wire logic [7:0] mem_rdata_in,
	output cfb_pkg::cfb_q_t q_out,
	output cfb_pkg::cfb_mem_t mem_out,
	output logic [20:0] pc_out,
	output logic pc_wr_out,
	output logic flush_out,
	output logic busy_out
);
	cfb_pkg::cfb_q_t q;
	cfb_pkg::cfb_state_t st_ff;
	cfb_pkg::cfb_state_t nxt_st;
	logic [20:0] br_target;
	logic [20:0] br_delta;

	cfb_qgen u_qgen (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.q_out(q)
	);

	// pc already points past this word; add doubled, sign-extended offset
	assign br_target = st_ff.pc + {{12{st_ff.data[7]}}, st_ff.data, 1'b0};
	assign br_delta = br_target - st_ff.pc;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pc_wr = 1'b0;
		nxt_st.mem.rd = 1'b0;
		nxt_st.mem.wr = 1'b0;
		case (q)
			cfb_pkg::CFB_Q1: begin
				nxt_st.busy = 1'b1;
				if (st_ff.flush) begin
					nxt_st.op = cfb_pkg::CFB_NOP;
					nxt_st.flush = 1'b0;
				end else if (!instr_valid_in) begin
					nxt_st.op = cfb_pkg::CFB_NONE;
				end else if (instr_in[15:12] == cfb_pkg::CLR_OPC) begin
					nxt_st.op = cfb_pkg::CFB_CLR;
					nxt_st.bit_sel = instr_in[11:9];
					nxt_st.acc_sel = instr_in[8];
					nxt_st.f_addr = instr_in[7:0];
				end else if (instr_in[15:8] == cfb_pkg::BRN_OPC) begin
					nxt_st.op = cfb_pkg::CFB_BRN;
					nxt_st.data = instr_in[7:0];
				end else begin
					nxt_st.op = cfb_pkg::CFB_NONE;
				end
				// dead cycle keeps the target: no word behind it to step over
				if (!st_ff.flush) begin
					nxt_st.pc = st_ff.pc + cfb_pkg::PC_STEP;
				end
			end
			cfb_pkg::CFB_Q2: begin
				if (st_ff.op == cfb_pkg::CFB_CLR) begin
					nxt_st.mem.rd = 1'b1;
					nxt_st.mem.idx = 1'b0;
					// quick bank: low half from bank 0, high half from the top bank
					if (st_ff.acc_sel) begin
						nxt_st.mem.addr = {bank_pointer_reg_in, st_ff.f_addr};
					end else if (ext_set_in && st_ff.f_addr <= cfb_pkg::IDX_MAX) begin
						nxt_st.mem.idx = 1'b1;
						nxt_st.mem.addr = {cfb_pkg::QUICK_BANK, st_ff.f_addr};
					end else if (st_ff.f_addr < cfb_pkg::QUICK_SPLIT) begin
						nxt_st.mem.addr = {cfb_pkg::QUICK_BANK, st_ff.f_addr};
					end else begin
						nxt_st.mem.addr = {cfb_pkg::QUICK_HI_BANK, st_ff.f_addr};
					end
				end
			end
			cfb_pkg::CFB_Q3: begin
				if (st_ff.op == cfb_pkg::CFB_CLR) begin
					nxt_st.mem.wdata = mem_rdata_in & ~(8'h01 << st_ff.bit_sel);
				end
			end
			default: begin
				nxt_st.busy = 1'b0;
				if (st_ff.op == cfb_pkg::CFB_CLR) begin
					nxt_st.mem.wr = 1'b1;
				end else if (st_ff.op == cfb_pkg::CFB_BRN && neg_flag_in) begin
					nxt_st.pc = br_target;
					nxt_st.pc_wr = 1'b1;
					nxt_st.flush = 1'b1;
				end else if (st_ff.op == cfb_pkg::CFB_BRN) begin
					nxt_st.pc_wr = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mem_out = st_ff.mem;
	assign pc_out = st_ff.pc;
	assign pc_wr_out = st_ff.pc_wr;
	assign flush_out = st_ff.flush;
	assign busy_out = st_ff.busy;
	assign q_out = q;

	property p_clr_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.rd |-> ##2 mem_out.wr;
	endproperty
	a_clr_wr: assert property (p_clr_wr) else $error("clear write not two after read");

	property p_clr_bit;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.wr |-> mem_out.wdata[st_ff.bit_sel] == 1'b0;
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("indexed bit not cleared");

	property p_clr_keep;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.rd ##1 1'b1 |-> ##1 ((mem_out.wdata | (8'h01 << st_ff.bit_sel))
			== ($past(mem_rdata_in, 2) | (8'h01 << st_ff.bit_sel)));
	endproperty
	a_clr_keep: assert property (p_clr_keep) else $error("other bits changed");

	property p_bank;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.rd && st_ff.acc_sel |-> mem_out.addr[11:8] == $past(bank_pointer_reg_in);
	endproperty
	a_bank: assert property (p_bank) else $error("bank pointer not used");

	property p_idx;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.rd |-> mem_out.idx == ($past(ext_set_in) && !st_ff.acc_sel
			&& st_ff.f_addr <= cfb_pkg::IDX_MAX);
	endproperty
	a_idx: assert property (p_idx) else $error("indexed mode wrong");

	property p_taken;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q4 && st_ff.op == cfb_pkg::CFB_BRN && neg_flag_in
		|=> pc_wr_out && pc_out == $past(br_target);
	endproperty
	a_taken: assert property (p_taken) else $error("taken branch wrong target");

	property p_not_taken;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q4 && st_ff.op == cfb_pkg::CFB_BRN && !neg_flag_in
		|=> !pc_wr_out && !flush_out;
	endproperty
	a_not_taken: assert property (p_not_taken) else $error("untaken branch wrote pc");

	property p_nop;
		@(posedge ref_clk_in) disable iff (rst_in)
		pc_wr_out |-> ##1 st_ff.op == cfb_pkg::CFB_NOP ##1 !mem_out.rd [*3];
	endproperty
	a_nop: assert property (p_nop) else $error("no nop cycle after branch");

	property p_sign;
		@(posedge ref_clk_in) disable iff (rst_in)
		st_ff.op == cfb_pkg::CFB_BRN
		|-> br_delta[cfb_pkg::PC_W - 1] == st_ff.data[7] && !br_delta[0];
	endproperty
	a_sign: assert property (p_sign) else $error("offset sign lost");

	property p_brn_decode;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q1 && !st_ff.flush && instr_valid_in
		&& instr_in[15:8] == cfb_pkg::BRN_OPC |=> st_ff.op == cfb_pkg::CFB_BRN;
	endproperty
	a_brn_decode: assert property (p_brn_decode) else $error("branch not decoded");

	property p_pc_step;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q1 && !st_ff.flush
		|=> pc_out == $past(pc_out) + cfb_pkg::PC_STEP;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc not stepped");

	property p_nop_pc;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q1 && st_ff.flush
		|=> st_ff.op == cfb_pkg::CFB_NOP && $stable(pc_out);
	endproperty
	a_nop_pc: assert property (p_nop_pc) else $error("dead cycle moved pc");

	property p_flush_len;
		@(posedge ref_clk_in) disable iff (rst_in)
		flush_out |=> !flush_out;
	endproperty
	a_flush_len: assert property (p_flush_len) else $error("flush held too long");

	property p_busy;
		@(posedge ref_clk_in) disable iff (rst_in)
		busy_out == (q != cfb_pkg::CFB_Q1);
	endproperty
	a_busy: assert property (p_busy) else $error("busy out of step");

	property p_quick_bank;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.rd && !st_ff.acc_sel && !mem_out.idx
		|-> mem_out.addr[11:8] == (st_ff.f_addr < cfb_pkg::QUICK_SPLIT
			? cfb_pkg::QUICK_BANK : cfb_pkg::QUICK_HI_BANK);
	endproperty
	a_quick_bank: assert property (p_quick_bank) else $error("quick bank half wrong");

	property p_wr_addr;
		@(posedge ref_clk_in) disable iff (rst_in)
		mem_out.wr |-> mem_out.addr == $past(mem_out.addr, 2);
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("write address moved");

	property p_clr_decode;
		@(posedge ref_clk_in) disable iff (rst_in)
		q == cfb_pkg::CFB_Q1 && !st_ff.flush && instr_valid_in
		&& instr_in[15:12] == cfb_pkg::CLR_OPC |=> st_ff.op == cfb_pkg::CFB_CLR;
	endproperty
	a_clr_decode: assert property (p_clr_decode) else $error("clear not decoded");
endmodule // cfb_exec

// file: design/cfb_qgen.sv
`timescale 1ns/1ps
// quarter-cycle sequencer, four clocks per instruction cycle
module cfb_qgen (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	output cfb_pkg::cfb_q_t q_out
);
	cfb_pkg::cfb_q_t q_ff;
	cfb_pkg::cfb_q_t nxt_q;

	always_comb begin
		case (q_ff)
			cfb_pkg::CFB_Q1: nxt_q = cfb_pkg::CFB_Q2;
			cfb_pkg::CFB_Q2: nxt_q = cfb_pkg::CFB_Q3;
			cfb_pkg::CFB_Q3: nxt_q = cfb_pkg::CFB_Q4;
			default: nxt_q = cfb_pkg::CFB_Q1;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q_ff <= cfb_pkg::CFB_Q1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign q_out = q_ff;
endmodule // cfb_qgen

// file: include/cfb_pkg.sv
package cfb_pkg;
	localparam logic [3:0] CLR_OPC = 4'h9;
	localparam logic [7:0] BRN_OPC = 8'he6;
	localparam logic [7:0] IDX_MAX = 8'h5f;
	localparam logic [3:0] QUICK_BANK = 4'h0;
	localparam logic [3:0] QUICK_HI_BANK = 4'hf;
	localparam logic [7:0] QUICK_SPLIT = 8'h80;
	localparam logic [20:0] PC_RST = 21'h000000;
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [1:0] Q_ZERO = 2'h0;
	localparam logic [1:0] Q_ONE = 2'h1;
	localparam int PC_W = 21;

	typedef enum logic [1:0] {CFB_Q1, CFB_Q2, CFB_Q3, CFB_Q4} cfb_q_t;
	typedef enum logic [1:0] {CFB_NONE, CFB_CLR, CFB_BRN, CFB_NOP} cfb_op_t;

	// data memory request toward the file array
	typedef struct packed {
		logic rd;
		logic wr;
		logic idx;
		logic [11:0] addr;
		logic [7:0] wdata;
	} cfb_mem_t;

	typedef struct packed {
		cfb_op_t op;
		logic [2:0] bit_sel;
		logic [7:0] f_addr;
		logic acc_sel;
		logic [7:0] data;
		logic [20:0] pc;
		logic pc_wr;
		logic flush;
		cfb_mem_t mem;
		logic busy;
	} cfb_state_t;
endpackage
